// [upc_top.sv]
// cell port address and configuration register bank with receive port
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "upc_map.svh"
module upc_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    // receive master side
    input  wire logic [4:0]  atm_rx_addr,
    input  wire logic        atm_rx_enb_n,
    // core cell source
    input  wire logic [23:0] core_cell_avail,
    input  wire logic [15:0] core_word,
    input  wire logic        core_soc,
    output logic             core_take,
    // receive pins
    output logic             rx_cell_available_out,
    output logic             rx_cell_available_out_oe,
    output logic [15:0]      rx_cell_data_out,
    output logic             rx_cell_data_out_oe,
    output logic             rx_cell_start_out,
    output logic             rx_cell_start_out_oe,
    output logic             rx_cell_parity_out,
    output logic             rx_cell_parity_out_oe,
    // transmit address match
    input  wire logic [4:0]  atm_tx_addr,
    output logic             tx_addr_hit,
    output logic [3:0]       tx_hit_link,
    // core control
    output logic             rx_sm_reset,
    output logic             rx_width_8bit
);
    logic [15:0] out_link_r [8];
    logic [15:0] out_grp_r  [4];
    logic [15:0] in_link_r  [8];
    logic [15:0] link_en_r;
    logic [15:0] grp_ctl_r;
    logic [15:0] udb_r;
    logic [15:0] rdata_r;
    logic        tx_hit_r;
    logic [3:0]  tx_link_r;

    upc_cfg_if cfg ();

    function automatic logic in_win(logic [7:0] a, logic [7:0] base, logic [7:0] m);
        return (a & m) == base;
    endfunction

    // address decode
    wire logic sel_out_link = in_win(reg_addr, `UPC_OUT_LINK_BASE, `UPC_WIN8_MASK);
    wire logic sel_out_grp  = in_win(reg_addr, `UPC_OUT_GRP_BASE, `UPC_WIN4_MASK);
    wire logic sel_in_link  = in_win(reg_addr, `UPC_IN_LINK_BASE, `UPC_WIN8_MASK);
    wire logic sel_link_en  = reg_addr == `UPC_OUT_LINK_EN;
    wire logic sel_grp_ctl  = reg_addr == `UPC_OUT_GRP_CTL;
    wire logic sel_udb      = reg_addr == `UPC_OUT_UDB;
    wire logic [2:0] idx8   = reg_addr[2:0];
    wire logic [1:0] idx4   = reg_addr[1:0];
    wire logic [15:0] wdata_addr = reg_wdata & `UPC_ADDR_MASK;

    // read selection; unmapped offsets read zero
    wire logic [15:0] rd_mux = sel_out_link ? out_link_r[idx8] :
                               sel_out_grp  ? out_grp_r[idx4]  :
                               sel_in_link  ? in_link_r[idx8]  :
                               sel_link_en  ? link_en_r        :
                               sel_grp_ctl  ? grp_ctl_r        :
                               sel_udb      ? udb_r            : 16'h0000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 8; i++) out_link_r[i] <= `UPC_RESET_VAL;
        end else if (reg_wr && sel_out_link) begin
            out_link_r[idx8] <= wdata_addr;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) out_grp_r[i] <= `UPC_RESET_VAL;
        end else if (reg_wr && sel_out_grp) begin
            out_grp_r[idx4] <= wdata_addr;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 8; i++) in_link_r[i] <= `UPC_RESET_VAL;
        end else if (reg_wr && sel_in_link) begin
            in_link_r[idx8] <= wdata_addr;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            link_en_r <= `UPC_RESET_VAL;
            grp_ctl_r <= `UPC_RESET_VAL;
            udb_r     <= `UPC_RESET_VAL;
        end else begin
            if (reg_wr && sel_link_en) link_en_r <= reg_wdata;
            if (reg_wr && sel_grp_ctl) grp_ctl_r <= reg_wdata & `UPC_GRP_CTL_MASK;
            if (reg_wr && sel_udb)     udb_r     <= reg_wdata & `UPC_UDB_MASK;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata = rdata_r;

    // configuration fan-out to the port
    upc_pkg::upc_tab_t out_tab;
    upc_pkg::upc_tab_t in_tab;
    logic [7:0][4:0]   grp_tab;

    always_comb begin
        for (int n = 0; n < 8; n++) begin
            out_tab[n]     = out_link_r[n][4:0];
            out_tab[n + 8] = out_link_r[n][12:8];
            in_tab[n]      = in_link_r[n][4:0];
            in_tab[n + 8]  = in_link_r[n][12:8];
        end
        for (int g = 0; g < 4; g++) begin
            grp_tab[g]     = out_grp_r[g][4:0];
            grp_tab[g + 4] = out_grp_r[g][12:8];
        end
    end

    assign cfg.link_addr = out_tab;
    assign cfg.grp_addr  = grp_tab;
    assign cfg.link_en   = link_en_r;
    assign cfg.grp_en    = grp_ctl_r[7:0];
    assign cfg.standby   = grp_ctl_r[`UPC_STANDBY_BIT];
    assign cfg.clav_ovr  = grp_ctl_r[`UPC_CLAV_OVR_BIT];
    assign cfg.data_ovr  = grp_ctl_r[`UPC_DATA_OVR_BIT];
    assign cfg.width8    = grp_ctl_r[`UPC_WIDTH8_BIT];
    assign cfg.sm_rst    = grp_ctl_r[`UPC_SMRST_BIT];
    assign cfg.par_even  = udb_r[`UPC_PAR_EVEN_BIT];
    assign cfg.par_tri   = udb_r[`UPC_PAR_TRI_BIT];
    assign cfg.udb       = udb_r[7:0];

    assign rx_sm_reset   = cfg.sm_rst;
    assign rx_width_8bit = cfg.width8;

    upc_rx_port u_port (
        .clk                      (clk),
        .resetn                   (resetn),
        .cfg                      (cfg),
        .atm_rx_addr              (atm_rx_addr),
        .atm_rx_enb_n             (atm_rx_enb_n),
        .core_cell_avail          (core_cell_avail),
        .core_word                (core_word),
        .core_soc                 (core_soc),
        .core_take                (core_take),
        .rx_cell_available_out    (rx_cell_available_out),
        .rx_cell_available_out_oe (rx_cell_available_out_oe),
        .rx_cell_data_out         (rx_cell_data_out),
        .rx_cell_data_out_oe      (rx_cell_data_out_oe),
        .rx_cell_start_out        (rx_cell_start_out),
        .rx_cell_start_out_oe     (rx_cell_start_out_oe),
        .rx_cell_parity_out       (rx_cell_parity_out),
        .rx_cell_parity_out_oe    (rx_cell_parity_out_oe)
    );

    // transmit-side address match against in-link table
    wire logic tx_hit_nxt = upc_pkg::upc_hit(in_tab, 16'hffff, atm_tx_addr);
    wire logic [3:0] tx_link_nxt = upc_pkg::upc_index(in_tab, 16'hffff, atm_tx_addr);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_hit_r  <= 1'b0;
            tx_link_r <= 4'h0;
        end else begin
            tx_hit_r  <= tx_hit_nxt;
            tx_link_r <= tx_link_nxt;
        end
    end

    assign tx_addr_hit = tx_hit_r;
    assign tx_hit_link = tx_link_r;

    // checking helpers
    wire logic poll_hit_chk =
        upc_pkg::upc_hit(out_tab, link_en_r, atm_rx_addr) ||
        upc_pkg::upc_hit({40'h0, grp_tab}, {8'h00, grp_ctl_r[7:0]}, atm_rx_addr);
    wire logic any_oe = rx_cell_available_out_oe | rx_cell_data_out_oe |
                        rx_cell_start_out_oe | rx_cell_parity_out_oe;
    wire logic addr_rd = reg_rd && (sel_out_link || sel_out_grp || sel_in_link);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_out_link_fields;
        reg_wr && reg_addr == `UPC_OUT_LINK_BASE |=>
            out_tab[0] == $past(reg_wdata[4:0]) && out_tab[8] == $past(reg_wdata[12:8]);
    endproperty
    a_out_link_fields: assert property (p_out_link_fields)
        else $error("out-link address fields not stored");

    property p_unused_zero;
        addr_rd |=> (reg_rdata & 16'he0e0) == 16'h0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused address bits read nonzero");

    property p_out_grp_fields;
        reg_wr && reg_addr == `UPC_OUT_GRP_BASE |=>
            grp_tab[0] == $past(reg_wdata[4:0]) && grp_tab[4] == $past(reg_wdata[12:8]);
    endproperty
    a_out_grp_fields: assert property (p_out_grp_fields)
        else $error("group address fields not stored");

    property p_link_en;
        reg_wr && reg_addr == `UPC_OUT_LINK_EN |=> cfg.link_en == $past(reg_wdata);
    endproperty
    a_link_en: assert property (p_link_en)
        else $error("link enable not stored");

    property p_grp_en;
        reg_wr && reg_addr == `UPC_OUT_GRP_CTL |=> cfg.grp_en == $past(reg_wdata[7:0]);
    endproperty
    a_grp_en: assert property (p_grp_en)
        else $error("group enable not stored");

    property p_standby;
        cfg.standby |-> !any_oe;
    endproperty
    a_standby: assert property (p_standby)
        else $error("pin driven in stand-by");

    property p_clav_ovr;
        cfg.clav_ovr && !cfg.standby |-> rx_cell_available_out_oe;
    endproperty
    a_clav_ovr: assert property (p_clav_ovr)
        else $error("cell-available not driven under override");

    property p_data_ovr;
        cfg.data_ovr && !cfg.standby |-> rx_cell_data_out_oe && rx_cell_start_out_oe;
    endproperty
    a_data_ovr: assert property (p_data_ovr)
        else $error("data pins not driven under override");

    property p_width8;
        core_take && cfg.width8 |=> rx_cell_data_out[15:8] == 8'h00;
    endproperty
    a_width8: assert property (p_width8)
        else $error("upper byte active in 8-bit mode");

    property p_sm_reset;
        cfg.sm_rst |-> !core_take ##1 (!cfg.sm_rst || !rx_cell_start_out);
    endproperty
    a_sm_reset: assert property (p_sm_reset)
        else $error("port active while held in reset");

    sequence s_hdr_words;
        core_take && core_soc && !cfg.width8 ##1 core_take && !core_soc
        ##1 core_take && !core_soc && !cfg.width8;
    endsequence

    property p_udb_insert;
        s_hdr_words |=> rx_cell_data_out[7:0] == $past(cfg.udb);
    endproperty
    a_udb_insert: assert property (p_udb_insert)
        else $error("user byte not in sixth header byte");

    property p_parity;
        $past(core_take) |-> rx_cell_parity_out ==
            upc_pkg::upc_parity(rx_cell_data_out, $past(cfg.width8), $past(cfg.par_even));
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity sense wrong");

    property p_par_tri;
        cfg.par_tri |-> !rx_cell_parity_out_oe;
    endproperty
    a_par_tri: assert property (p_par_tri)
        else $error("parity driven while tristated");

    property p_par_drive;
        !cfg.par_tri |-> rx_cell_parity_out_oe == rx_cell_data_out_oe;
    endproperty
    a_par_drive: assert property (p_par_drive)
        else $error("parity drive differs from data drive");

    property p_take_drive;
        core_take |=> rx_cell_data_out_oe || cfg.standby;
    endproperty
    a_take_drive: assert property (p_take_drive)
        else $error("data pins not driven after a take");

    sequence s_in_link_wr_rd;
        reg_wr && reg_addr == `UPC_IN_LINK_BASE ##1 !(reg_wr && reg_addr == `UPC_IN_LINK_BASE)
        ##1 reg_rd && reg_addr == `UPC_IN_LINK_BASE;
    endsequence

    property p_in_link;
        s_in_link_wr_rd |=> reg_rdata == ($past(reg_wdata, 3) & `UPC_ADDR_MASK);
    endproperty
    a_in_link: assert property (p_in_link)
        else $error("in-link address readback wrong");

    property p_poll_answer;
        !cfg.clav_ovr && rx_cell_available_out_oe && !$past(cfg.sm_rst) |->
            $past(poll_hit_chk);
    endproperty
    a_poll_answer: assert property (p_poll_answer)
        else $error("answered poll of unassigned address");

endmodule
`default_nettype wire

// [upc_map.svh]
// register offsets, field positions and masks of the cell port configuration bank
`ifndef UPC_MAP_SVH
`define UPC_MAP_SVH

// register offsets
`define UPC_OUT_LINK_BASE   8'h00
`define UPC_OUT_GRP_BASE    8'h08
`define UPC_OUT_LINK_EN     8'h10
`define UPC_OUT_GRP_CTL     8'h11
`define UPC_OUT_UDB         8'h12
`define UPC_IN_LINK_BASE    8'h40

// window masks for multi-register blocks
`define UPC_WIN8_MASK       8'hf8
`define UPC_WIN4_MASK       8'hfc

// writable bit masks and register reset value
`define UPC_ADDR_MASK       16'h1f1f
`define UPC_GRP_CTL_MASK    16'h7fff
`define UPC_UDB_MASK        16'h0fff
`define UPC_RESET_VAL       16'h0000

// field positions
`define UPC_STANDBY_BIT     14
`define UPC_CLAV_OVR_BIT    13
`define UPC_DATA_OVR_BIT    12
`define UPC_WIDTH8_BIT      11
`define UPC_SMRST_BIT       9
`define UPC_PAR_TRI_BIT     9
`define UPC_PAR_EVEN_BIT    8

// header word holding the user byte in 16-bit mode
`define UPC_UDB_WORD        5'h02

`endif

// [upc_pkg.sv]
// types and shared functions of the cell port configuration bank
`default_nettype none
package upc_pkg;

    typedef logic [4:0]       upc_phy_t;
    typedef logic [15:0][4:0] upc_tab_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_SEND  = 3'b100
    } upc_port_st_t;

    function automatic logic upc_hit(upc_tab_t tab, logic [15:0] en, upc_phy_t a);
        logic h;
        h = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (en[i] && tab[i] == a) h = 1'b1;
        end
        return h;
    endfunction

    function automatic logic [3:0] upc_index(upc_tab_t tab, logic [15:0] en, upc_phy_t a);
        logic [3:0] k;
        k = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (en[i] && tab[i] == a) k = 4'(i);
        end
        return k;
    endfunction

    function automatic logic upc_parity(logic [15:0] d, logic w8, logic even);
        logic x;
        x = w8 ? ^d[7:0] : ^d;
        return even ? x : ~x;
    endfunction

endpackage
`default_nettype wire

// [upc_cfg_if.sv]
// configuration carried from the register bank to the receive port logic
`timescale 1ns/1ps
`default_nettype none
interface upc_cfg_if;
    upc_pkg::upc_tab_t link_addr;
    logic [15:0]       link_en;
    logic [7:0][4:0]   grp_addr;
    logic [7:0]        grp_en;
    logic              standby;
    logic              clav_ovr;
    logic              data_ovr;
    logic              width8;
    logic              sm_rst;
    logic              par_even;
    logic              par_tri;
    logic [7:0]        udb;

    modport regs (output link_addr, link_en, grp_addr, grp_en, standby, clav_ovr,
                  data_ovr, width8, sm_rst, par_even, par_tri, udb);
    modport port (input link_addr, link_en, grp_addr, grp_en, standby, clav_ovr,
                  data_ovr, width8, sm_rst, par_even, par_tri, udb);
endinterface
`default_nettype wire

// [upc_rx_port.sv]
// receive-direction cell port: address poll, select, word output, pin enables
`timescale 1ns/1ps
`default_nettype none
`include "upc_map.svh"
module upc_rx_port (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // configuration
    upc_cfg_if.port          cfg,
    // master side
    input  wire logic [4:0]  atm_rx_addr,
    input  wire logic        atm_rx_enb_n,
    // core side
    input  wire logic [23:0] core_cell_avail,
    input  wire logic [15:0] core_word,
    input  wire logic        core_soc,
    output logic             core_take,
    // pins
    output logic             rx_cell_available_out,
    output logic             rx_cell_available_out_oe,
    output logic [15:0]      rx_cell_data_out,
    output logic             rx_cell_data_out_oe,
    output logic             rx_cell_start_out,
    output logic             rx_cell_start_out_oe,
    output logic             rx_cell_parity_out,
    output logic             rx_cell_parity_out_oe
);
    upc_pkg::upc_port_st_t st_r, st_nxt;
    logic        clav_r, clav_drv_r, drv_r, soc_r, par_r;
    logic [15:0] data_r;
    logic [4:0]  widx_r;

    wire upc_pkg::upc_tab_t grp_tab  = {40'h0, cfg.grp_addr};
    wire logic [15:0]       grp_en16 = {8'h00, cfg.grp_en};
    wire logic link_hit = upc_pkg::upc_hit(cfg.link_addr, cfg.link_en, atm_rx_addr);
    wire logic grp_hit  = upc_pkg::upc_hit(grp_tab, grp_en16, atm_rx_addr);
    wire logic [3:0] link_idx = upc_pkg::upc_index(cfg.link_addr, cfg.link_en, atm_rx_addr);
    wire logic [3:0] grp_idx  = upc_pkg::upc_index(grp_tab, grp_en16, atm_rx_addr);
    wire logic poll_hit = link_hit | grp_hit;
    wire logic avail    = link_hit ? core_cell_avail[{1'b0, link_idx}]
                                   : core_cell_avail[{2'b10, grp_idx[2:0]}];
    wire logic [4:0] cur_widx = core_soc ? 5'h00 : widx_r;
    wire logic udb_slot = !cfg.width8 && cur_widx == `UPC_UDB_WORD;
    wire logic [15:0] data_nxt = cfg.width8 ? {8'h00, core_word[7:0]} :
                                 udb_slot ? {core_word[15:8], cfg.udb} : core_word;

    assign core_take = (st_r == upc_pkg::ST_SEND) && !atm_rx_enb_n && !cfg.sm_rst;

    always_comb begin
        case (st_r)
            upc_pkg::ST_IDLE:  st_nxt = (atm_rx_enb_n && poll_hit) ? upc_pkg::ST_ARMED
                                                                   : upc_pkg::ST_IDLE;
            upc_pkg::ST_ARMED: st_nxt = !atm_rx_enb_n ? upc_pkg::ST_SEND :
                                        poll_hit ? upc_pkg::ST_ARMED : upc_pkg::ST_IDLE;
            upc_pkg::ST_SEND:  st_nxt = !atm_rx_enb_n ? upc_pkg::ST_SEND :
                                        poll_hit ? upc_pkg::ST_ARMED : upc_pkg::ST_IDLE;
            default:           st_nxt = upc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r       <= upc_pkg::ST_IDLE;
            clav_r     <= 1'b0;
            clav_drv_r <= 1'b0;
            drv_r      <= 1'b0;
        end else if (cfg.sm_rst) begin
            st_r       <= upc_pkg::ST_IDLE;
            clav_r     <= 1'b0;
            clav_drv_r <= 1'b0;
            drv_r      <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            clav_r     <= poll_hit & avail;
            clav_drv_r <= poll_hit;
            drv_r      <= core_take;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_r <= 16'h0000;
            soc_r  <= 1'b0;
            par_r  <= 1'b0;
            widx_r <= 5'h00;
        end else if (cfg.sm_rst) begin
            soc_r  <= 1'b0;
            widx_r <= 5'h00;
        end else if (core_take) begin
            data_r <= data_nxt;
            soc_r  <= core_soc;
            par_r  <= upc_pkg::upc_parity(data_nxt, cfg.width8, cfg.par_even);
            widx_r <= cur_widx + 5'h01;
        end
    end

    assign rx_cell_available_out    = clav_r;
    assign rx_cell_data_out         = data_r;
    assign rx_cell_start_out        = soc_r;
    assign rx_cell_parity_out       = par_r;
    assign rx_cell_available_out_oe = !cfg.standby && (cfg.clav_ovr || clav_drv_r);
    assign rx_cell_data_out_oe      = !cfg.standby && (cfg.data_ovr || drv_r);
    assign rx_cell_start_out_oe     = rx_cell_data_out_oe;
    assign rx_cell_parity_out_oe    = rx_cell_data_out_oe && !cfg.par_tri;
endmodule
`default_nettype wire

// [upc_atm_master.sv]
// receive-side master model: polls the cell port by address
`timescale 1ns/1ps
`default_nettype none
module upc_atm_master (
    // clock
    input  wire logic clk,
    // master drive
    output logic [4:0] rx_addr,
    output logic       rx_enb_n
);
    initial begin
        rx_addr  = 5'h1f;
        rx_enb_n = 1'b1;
    end

    // poll edge with enable high, then the address moves off
    task automatic poll(input logic [4:0] a);
        @(posedge clk);
        rx_addr  <= a;
        rx_enb_n <= 1'b1;
        @(posedge clk);
        rx_addr  <= ~a;
    endtask

    // arm by a poll, then hold enable low for n edges
    task automatic select(input logic [4:0] a, input int n);
        @(posedge clk);
        rx_addr  <= a;
        rx_enb_n <= 1'b1;
        @(posedge clk);
        rx_enb_n <= 1'b0;
        repeat (n) @(posedge clk);
        rx_enb_n <= 1'b1;
        rx_addr  <= ~a;
    endtask
endmodule
`default_nettype wire

// [upc_top_tb.sv]
// self-checking bench of the cell port configuration bank
`timescale 1ns/1ps
`default_nettype none
module upc_top_tb;
    logic        clk, resetn, reg_wr, reg_rd, core_soc, atm_rx_enb_n, rd_d;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, core_word, d;
    logic [23:0] core_cell_avail;
    logic [4:0]  atm_rx_addr, atm_tx_addr;
    logic        rx_cell_available_out, rx_cell_available_out_oe, rx_cell_data_out_oe;
    logic        rx_cell_start_out_oe, rx_cell_parity_out_oe, tx_addr_hit, rx_sm_reset;
    logic        rx_width_8bit;
    logic [3:0]  tx_hit_link;
    logic        core_take, rx_cell_start_out, rx_cell_parity_out, take_n, w8_e, pe_e;
    logic [15:0] rx_cell_data_out;
    logic [7:0]  udb_e;
    logic [17:0] dexp_q [$];
    logic [17:0] dx;
    int          wi;
    int          ntake = 0;
    logic [15:0] exp_q [$];
    logic [7:0]  ra [3] = '{8'h03, 8'h03, 8'h09};
    logic [15:0] rv [3] = '{16'h000d, 16'h0d00, 16'h0d00};
    logic [7:0]  ea [3] = '{8'h10, 8'h10, 8'h11};
    logic [15:0] ev [3] = '{16'h0008, 16'h0800, 16'h0020};
    int          bi [3] = '{3, 11, 21};
    int          seed = 98581;
    int          miscompares = 0;
    int          comparisons = 0;

    upc_top dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .atm_rx_addr, .atm_rx_enb_n, .core_cell_avail, .core_word, .core_soc, .core_take,
        .rx_cell_available_out, .rx_cell_available_out_oe, .rx_cell_data_out,
        .rx_cell_data_out_oe, .rx_cell_start_out, .rx_cell_start_out_oe,
        .rx_cell_parity_out, .rx_cell_parity_out_oe, .atm_tx_addr, .tx_addr_hit,
        .tx_hit_link, .rx_sm_reset, .rx_width_8bit);
    upc_atm_master master (.clk(clk), .rx_addr(atm_rx_addr), .rx_enb_n(atm_rx_enb_n));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [15:0] wmask(input logic [7:0] a);
        if (a < 8'h0c || (a >= 8'h40 && a < 8'h48)) return 16'h1f1f;
        if (a == 8'h10) return 16'hffff;
        if (a == 8'h11) return 16'h7fff;
        if (a == 8'h12) return 16'h0fff;
        return 16'h0000;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);

    // expected output word: 8-bit in low byte, user byte in word 2 of 16-bit
    function automatic logic [15:0] dword(input logic [15:0] w, input int i);
        if (w8_e) return {8'h00, w[7:0]};
        if (i == 2) return {w[15:8], udb_e};
        return w;
    endfunction

    function automatic logic pexp(input logic [15:0] v, input logic ev);
        return ev ? ^v : ~^v;
    endfunction

    // core cell source: a fresh random word after every take
    always @(posedge clk) begin
        if (!resetn) begin
            core_word <= 16'($random(seed));
            core_soc  <= 1'b1;
            wi        <= 0;
        end else if (take_n) begin
            dexp_q.push_back({core_soc, pexp(dword(core_word, wi), pe_e),
                              dword(core_word, wi)});
            ntake++;
            wi        <= wi + 1;
            core_soc  <= 1'b0;
            core_word <= 16'($random(seed));
        end
    end

    // output word stands from the take edge until the next take
    always @(negedge clk) begin
        if (take_n) begin
            dx = dexp_q.pop_front();
            chk("rx data", dx[15:0], rx_cell_data_out);
            chk("rx soc par", {14'h0, dx[17:16]}, {14'h0, rx_cell_start_out,
                rx_cell_parity_out});
        end
        take_n <= core_take;
    end

    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        atm_tx_addr = 5'h00;
        core_cell_avail = 24'($random(seed));
        resetn = 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 'h50; i++) rd(i[7:0], 16'h0000);
        $display("test reset values done");
        for (int i = 0; i < 'h50; i++) begin
            d = 16'($random(seed));
            if (i == 'h11) d = d & 16'hfaff;
            wr(i[7:0], d);
            rd(i[7:0], d & wmask(i[7:0]));
        end
        $display("test register access done");
        wr(8'h10, 16'h0000);
        wr(8'h11, 16'h0000);
        wr(8'h12, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            wr(ra[k], rv[k]);
            wr(ea[k], ev[k]);
            master.poll(5'h0d);
            #1;
            chk("clav_oe", 16'h0001, {15'h0, rx_cell_available_out_oe});
            chk("clav", {15'h0, core_cell_avail[bi[k]]}, {15'h0, rx_cell_available_out});
            wr(ea[k], 16'h0000);
            master.poll(5'h0d);
            #1;
            chk("clav_oe off", 16'h0000, {15'h0, rx_cell_available_out_oe});
        end
        $display("test address poll done");
        wr(8'h11, 16'h4020);
        master.poll(5'h0d);
        #1;
        chk("clav_oe standby", 16'h0000, {15'h0, rx_cell_available_out_oe});
        wr(8'h11, 16'h3a00);
        settle;
        chk("clav_oe ovr", 16'h0001, {15'h0, rx_cell_available_out_oe});
        chk("pin oe ovr", 16'h0007, {13'h0, rx_cell_data_out_oe, rx_cell_start_out_oe,
            rx_cell_parity_out_oe});
        chk("width8", 16'h0001, {15'h0, rx_width_8bit});
        chk("sm_reset", 16'h0001, {15'h0, rx_sm_reset});
        wr(8'h12, 16'h0200);
        settle;
        chk("parity oe", 16'h0000, {15'h0, rx_cell_parity_out_oe});
        wr(8'h11, 16'h0000);
        settle;
        chk("width16", 16'h0000, {15'h0, rx_width_8bit});
        $display("test port control done");
        for (int i = 'h40; i < 'h48; i++) wr(i[7:0], 16'h0000);
        wr(8'h45, 16'h1600);
        atm_tx_addr <= 5'h16;
        settle;
        chk("tx_hit", 16'h0001, {15'h0, tx_addr_hit});
        chk("tx_link", 16'h000d, {12'h0, tx_hit_link});
        $display("test transmit match done");
        wr(8'h10, 16'h0800);
        wr(8'h12, 16'h01a5);
        udb_e = 8'ha5;
        pe_e  = 1'b1;
        w8_e  = 1'b0;
        master.select(5'h0d, 5);
        wr(8'h12, 16'h00c3);
        wr(8'h11, 16'h0800);
        w8_e = 1'b1;
        pe_e = 1'b0;
        master.select(5'h0d, 4);
        settle;
        chk("takes", 16'h0007, 16'(ntake));
        $display("test cell output done");
        stop_test;
    end

    initial begin
        #(4000 * 20);
        miscompares++;
        stop_test;
    end
endmodule
`default_nettype wire
